/* File: verilog/mca_pkg.sv */
// Package with register map, field positions and addresses for the mission setup block
package mca_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 8;
  localparam int          PTR_W           = 16;
  localparam logic [15:0] ADDR_MISSION    = 16'h0213;
  localparam logic [15:0] ADDR_ALARM      = 16'h0214;
  localparam logic [15:0] ADDR_SENS_CTRL  = 16'h0210;
  localparam logic [15:0] ADDR_DATA_CTRL  = 16'h0211;
  localparam logic [15:0] ADDR_MISC       = 16'h0230;
  // Mission setup field positions
  localparam int          B_TEMP_LOG      = 0;
  localparam int          B_SER_LOG       = 1;
  localparam int          B_TEMP_WS       = 2;
  localparam int          B_SER_WS        = 3;
  localparam int          B_WRAP          = 4;
  localparam int          B_START_ON_TEMP_ALARM          = 5;
  // Alarm flag positions
  localparam int          B_TLF           = 0;
  localparam int          B_THF           = 1;
  localparam int          B_DLF           = 2;
  localparam int          B_DHF           = 3;
  localparam int          B_PWR           = 7;
  localparam logic [7:0]  MISSION_FORCE1  = 8'hC0;
  localparam logic [7:0]  MISSION_WMASK   = 8'h3F;
  localparam logic [7:0]  ALARM_FORCE1    = 8'h70;
  localparam logic [7:0]  SENS_WMASK      = 8'h03;
  localparam logic [7:0]  DATA_FORCE1     = 8'hFC;
  localparam logic [7:0]  MISSION_RST     = 8'hC0;
  localparam logic [7:0]  ALARM_RST       = 8'h80;
  // Datalog addresses
  localparam logic [15:0] LOG_BASE        = 16'h1000;
  localparam logic [15:0] LOG_END         = 16'h2FFF;
  localparam logic [15:0] SER_BASE_EQ     = 16'h2000;
  localparam logic [15:0] SER_BASE_T8D16  = 16'h1A00;
  localparam logic [15:0] SER_BASE_T16D8  = 16'h2400;
  localparam logic [15:0] PTR_ONE         = 16'h0001;
  localparam logic [15:0] PTR_TWO         = 16'h0002;
endpackage : mca_pkg

/* File: verilog/mca_mission_config.sv */
// Mission configuration, alarm flags and datalog write sequencing
//
// Operation
// [R1] Setup register bits 7:6 read one; writes of zero there ignored.
// [R2] Setup register writes blocked while a mission is active.
// [R3] Bit 0 enables temperature log, always stored from 1000h.
// [R4] Mission start refused unless temperature or serial logging enabled.
// [R5] Serial-only logging stores serial records from 1000h.
// [R6] Both logs: serial base 2000h equal formats, 1A00h T8/D16, 2400h T16/D8.
// [R7] Bit 2 selects 8-bit (0) or 16-bit (1) temperature records.
// [R8] Bit 3 selects 8-bit (0) or 16-bit (1) serial records.
// [R9] 16-bit record: high byte at lower address, low byte next.
// [R10] Bit 4 set: logging wraps to memory start when full.
// [R11] Bit 4 clear: logging stops when full; mission stays active until stop.
// [R12] Bit 5: 8-bit conversions each sample, log only after temperature alarm.
// [R13] First record written one sample period after the triggering alarm.
// [R14] Start on alarm only effective with temperature logging enabled.
// [R15] Alarm register read-only; bits 6:4 read one.
// [R16] Clear memory clears all five alarm flags at once.
// [R17] Low temperature flag latches when result at or below low threshold, enabled.
// [R18] High temperature flag latches when result at or above high threshold, enabled.
// [R19] Data low flag latches when serial value at or below threshold, enabled.
// [R20] Data high flag latches when serial value at or above threshold, enabled.
// [R21] Triggering alarm and forced conversions may also set temperature flags.
// [R22] Power flag set on every power-on reset, always enabled.
// [R23] Comparison flags set only with their enable bits; temp enables at 0210h.
// [R24] Flags stay latched until clear memory or power-on reset.
`timescale 1ns/1ps
module mca_mission_config (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_start_mission,
  input  wire logic        i_stop_mission,
  input  wire logic        i_clear_memory,
  input  wire logic        i_sample_tick,
  input  wire logic        i_conv_done,
  input  wire logic        i_conv_forced,
  input  wire logic [15:0] i_temp_value,
  input  wire logic [7:0]  i_temp_low_thr,
  input  wire logic [7:0]  i_temp_high_thr,
  input  wire logic        i_ser_done,
  input  wire logic [15:0] i_ser_value,
  input  wire logic [7:0]  i_data_low_thr,
  input  wire logic [7:0]  i_data_high_thr,
  output logic             o_mission_active,
  output logic             o_waiting_alarm,
  output logic             o_start_refused,
  output logic             o_conv_8bit,
  output logic             o_conv_enable,
  output logic             o_mem_we,
  output logic      [15:0] o_mem_addr,
  output logic      [7:0]  o_mem_wdata,
  output logic      [15:0] o_temp_base,
  output logic      [15:0] o_ser_base
);

  typedef enum logic [2:0] {
    MCA_IDLE,
    MCA_WAIT_ALARM,
    MCA_ARMED,
    MCA_LOG,
    MCA_FULL
  } mca_state_e;

  typedef enum logic [2:0] {
    MCA_WR_NONE,
    MCA_WR_T_HI,
    MCA_WR_T_LO,
    MCA_WR_S_HI,
    MCA_WR_S_LO
  } mca_wr_e;

  mca_state_e   state_ff, nxt_state;
  mca_wr_e      wr_ff, nxt_wr;
  logic [7:0]   setup_ff, nxt_setup;
  logic [7:0]   flags_ff, nxt_flags;
  logic [1:0]   sens_en_ff, nxt_sens_en;
  logic [1:0]   data_en_ff, nxt_data_en;
  logic [7:0]   rdata_ff, nxt_rdata;
  logic         refused_ff, nxt_refused;
  logic [15:0]  tptr_ff, nxt_tptr;
  logic [15:0]  sptr_ff, nxt_sptr;
  logic [15:0]  tval_ff, nxt_tval;
  logic [15:0]  sval_ff, nxt_sval;
  logic         ser_pend_ff, nxt_ser_pend;
  logic         we_ff, nxt_we;
  logic [15:0]  maddr_ff, nxt_maddr;
  logic [7:0]   mdata_ff, nxt_mdata;

  logic         active;
  logic         t_en, s_en, t16, s16, wrap, start_on_temp_alarm_eff;
  logic [15:0]  ser_base;
  logic [15:0]  temp_end;
  logic         t_low, t_high, d_low, d_high;
  logic [7:0]   setup_rd, alarm_rd;

  // Field decode
  always_comb
  begin
    t_en     = setup_ff[mca_pkg::B_TEMP_LOG];
    s_en     = setup_ff[mca_pkg::B_SER_LOG];
    t16      = setup_ff[mca_pkg::B_TEMP_WS];                                 // [R7]
    s16      = setup_ff[mca_pkg::B_SER_WS];                                  // [R8]
    wrap     = setup_ff[mca_pkg::B_WRAP];
    start_on_temp_alarm_eff = setup_ff[mca_pkg::B_START_ON_TEMP_ALARM] & t_en;                             // [R14]
    active   = (state_ff != MCA_IDLE);
    if (!t_en || (t16 == s16))
      ser_base = t_en ? mca_pkg::SER_BASE_EQ : mca_pkg::LOG_BASE;            // [R5] [R6]
    else if (s16)
      ser_base = mca_pkg::SER_BASE_T8D16;                                    // [R6]
    else
      ser_base = mca_pkg::SER_BASE_T16D8;                                    // [R6]
    // Temperature region stops below the serial base when both logs share memory
    if (t_en && s_en)
      temp_end = ser_base - mca_pkg::PTR_ONE;                                // [R6]
    else
      temp_end = mca_pkg::LOG_END;
    // Comparisons on the most significant byte
    t_low    = i_temp_value[15:8] <= i_temp_low_thr;
    t_high   = i_temp_value[15:8] >= i_temp_high_thr;
    d_low    = i_ser_value[15:8] <= i_data_low_thr;
    d_high   = i_ser_value[15:8] >= i_data_high_thr;
    setup_rd = setup_ff | mca_pkg::MISSION_FORCE1;                           // [R1]
    alarm_rd = flags_ff | mca_pkg::ALARM_FORCE1;                             // [R15]
  end

  // Register file
  always_comb
  begin
    nxt_setup   = setup_ff;
    nxt_sens_en = sens_en_ff;
    nxt_data_en = data_en_ff;
    nxt_rdata   = 8'h00;
    if (i_wr && !active)                                                     // [R2]
    begin
      case (i_addr)
        mca_pkg::ADDR_MISSION:
          nxt_setup = (i_wdata & mca_pkg::MISSION_WMASK) | mca_pkg::MISSION_FORCE1; // [R1]
        mca_pkg::ADDR_SENS_CTRL:
          nxt_sens_en = i_wdata[1:0];
        mca_pkg::ADDR_DATA_CTRL:
          nxt_data_en = i_wdata[1:0];
        default:
          nxt_setup = setup_ff;
      endcase
    end
    if (i_rd)
    begin
      case (i_addr)
        mca_pkg::ADDR_MISSION:   nxt_rdata = setup_rd;
        mca_pkg::ADDR_ALARM:     nxt_rdata = alarm_rd;
        mca_pkg::ADDR_SENS_CTRL: nxt_rdata = {6'h00, sens_en_ff};
        mca_pkg::ADDR_DATA_CTRL: nxt_rdata = mca_pkg::DATA_FORCE1 | {6'h00, data_en_ff};
        mca_pkg::ADDR_MISC:      nxt_rdata = {3'h0, o_waiting_alarm, refused_ff, 1'b0, active, 1'b0};
        default:                 nxt_rdata = 8'h00;
      endcase
    end
  end

  // Alarm flags; set wins over clear memory
  always_comb
  begin
    nxt_flags = flags_ff;
    if (i_clear_memory)
      nxt_flags = 8'h00;                                                     // [R16] [R24]
    if (i_conv_done && (active || i_conv_forced))                            // [R21]
    begin
      if (t_low && sens_en_ff[0])
        nxt_flags[mca_pkg::B_TLF] = 1'b1;                                    // [R17] [R23]
      if (t_high && sens_en_ff[1])
        nxt_flags[mca_pkg::B_THF] = 1'b1;                                    // [R18] [R23]
    end
    if (i_ser_done && (active || i_conv_forced))
    begin
      if (d_low && data_en_ff[0])
        nxt_flags[mca_pkg::B_DLF] = 1'b1;                                    // [R19] [R23]
      if (d_high && data_en_ff[1])
        nxt_flags[mca_pkg::B_DHF] = 1'b1;                                    // [R20] [R23]
    end
  end

  // Mission sequencing and record writes
  always_comb
  begin
    nxt_state    = state_ff;
    nxt_refused  = refused_ff;
    nxt_tptr     = tptr_ff;
    nxt_sptr     = sptr_ff;
    nxt_tval     = tval_ff;
    nxt_sval     = sval_ff;
    nxt_ser_pend = ser_pend_ff;
    nxt_wr       = MCA_WR_NONE;
    nxt_we       = 1'b0;
    nxt_maddr    = maddr_ff;
    nxt_mdata    = mdata_ff;
    case (state_ff)
      MCA_IDLE:
      begin
        if (i_start_mission)
        begin
          nxt_refused = !(t_en || s_en);                                     // [R4]
          nxt_tptr    = mca_pkg::LOG_BASE;                                   // [R3]
          nxt_sptr    = ser_base;
          nxt_ser_pend = 1'b0;
          if (t_en || s_en)
            nxt_state = start_on_temp_alarm_eff ? MCA_WAIT_ALARM : MCA_LOG;                 // [R12]
        end
      end
      MCA_WAIT_ALARM:
        if (i_conv_done && ((t_low && sens_en_ff[0]) || (t_high && sens_en_ff[1])))
          nxt_state = MCA_ARMED;                                             // [R12]
      MCA_ARMED:
        if (i_sample_tick)
          nxt_state = MCA_LOG;                                               // [R13]
      MCA_LOG:
      begin
        if (i_conv_done && t_en)
        begin
          nxt_tval = i_temp_value;
          nxt_wr   = t16 ? MCA_WR_T_HI : MCA_WR_T_LO;
        end
        if (i_ser_done && s_en)
        begin
          nxt_sval     = i_ser_value;
          nxt_ser_pend = 1'b1;
        end
        case (wr_ff)
          MCA_WR_T_HI:
          begin
            nxt_we    = 1'b1;
            nxt_maddr = tptr_ff;
            nxt_mdata = tval_ff[15:8];                                       // [R9]
            nxt_tptr  = tptr_ff + mca_pkg::PTR_ONE;
            nxt_wr    = MCA_WR_T_LO;
          end
          MCA_WR_T_LO:
          begin
            nxt_we    = 1'b1;
            nxt_maddr = tptr_ff;
            nxt_mdata = t16 ? tval_ff[7:0] : tval_ff[15:8];                  // [R9] [R7]
            nxt_tptr  = tptr_ff + mca_pkg::PTR_ONE;
          end
          MCA_WR_S_HI:
          begin
            nxt_we    = 1'b1;
            nxt_maddr = sptr_ff;
            nxt_mdata = sval_ff[15:8];                                       // [R9]
            nxt_sptr  = sptr_ff + mca_pkg::PTR_ONE;
            nxt_wr    = MCA_WR_S_LO;
          end
          MCA_WR_S_LO:
          begin
            nxt_we    = 1'b1;
            nxt_maddr = sptr_ff;
            nxt_mdata = s16 ? sval_ff[7:0] : sval_ff[15:8];                  // [R9] [R8]
            nxt_sptr  = sptr_ff + mca_pkg::PTR_ONE;
          end
          default:
            if (ser_pend_ff && nxt_wr == MCA_WR_NONE)
            begin
              nxt_ser_pend = 1'b0;
              nxt_wr       = s16 ? MCA_WR_S_HI : MCA_WR_S_LO;
            end
        endcase
        // End of memory handling
        if (nxt_tptr > temp_end || nxt_sptr > mca_pkg::LOG_END)
        begin
          if (wrap)
          begin
            nxt_tptr = mca_pkg::LOG_BASE;                                    // [R10]
            nxt_sptr = ser_base;                                             // [R10]
          end
          else
          begin
            nxt_state = MCA_FULL;                                            // [R11]
            nxt_wr    = MCA_WR_NONE;
          end
        end
      end
      MCA_FULL:
      begin
        nxt_state    = MCA_FULL;                                             // [R11]
        nxt_ser_pend = 1'b0;
      end
      default:
        nxt_state = MCA_IDLE;
    endcase
    if (i_stop_mission)
    begin
      nxt_state    = MCA_IDLE;
      nxt_ser_pend = 1'b0;
    end
  end

  // Register file state
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      setup_ff    <= mca_pkg::MISSION_RST;
      sens_en_ff  <= 2'b00;
      data_en_ff  <= 2'b00;
      rdata_ff    <= 8'h00;
    end
    else
    begin
      setup_ff    <= nxt_setup;
      sens_en_ff  <= nxt_sens_en;
      data_en_ff  <= nxt_data_en;
      rdata_ff    <= nxt_rdata;
    end
  end

  // Alarm flag state
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      flags_ff    <= mca_pkg::ALARM_RST;                                     // [R22]
    end
    else
    begin
      flags_ff    <= nxt_flags;
    end
  end

  // Mission and record write state
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      state_ff    <= MCA_IDLE;
      wr_ff       <= MCA_WR_NONE;
      refused_ff  <= 1'b0;
      tptr_ff     <= mca_pkg::LOG_BASE;
      sptr_ff     <= mca_pkg::LOG_BASE;
      tval_ff     <= 16'h0000;
      sval_ff     <= 16'h0000;
      ser_pend_ff <= 1'b0;
      we_ff       <= 1'b0;
      maddr_ff    <= 16'h0000;
      mdata_ff    <= 8'h00;
    end
    else
    begin
      state_ff    <= nxt_state;
      wr_ff       <= nxt_wr;
      refused_ff  <= nxt_refused;
      tptr_ff     <= nxt_tptr;
      sptr_ff     <= nxt_sptr;
      tval_ff     <= nxt_tval;
      sval_ff     <= nxt_sval;
      ser_pend_ff <= nxt_ser_pend;
      we_ff       <= nxt_we;
      maddr_ff    <= nxt_maddr;
      mdata_ff    <= nxt_mdata;
    end
  end

  // Outputs
  assign o_rdata          = rdata_ff;
  assign o_mission_active = active;                                          // [R11]
  assign o_waiting_alarm  = (state_ff == MCA_WAIT_ALARM);
  assign o_start_refused  = refused_ff;
  assign o_conv_8bit      = (state_ff == MCA_WAIT_ALARM) || !t16;            // [R12]
  assign o_conv_enable    = active && (state_ff != MCA_FULL);                // [R11]
  assign o_mem_we         = we_ff;
  assign o_mem_addr       = maddr_ff;
  assign o_mem_wdata      = mdata_ff;
  assign o_temp_base      = mca_pkg::LOG_BASE;                               // [R3]
  assign o_ser_base       = ser_base;

endmodule : mca_mission_config

/* File: dv/mca_mission_config_assertions.sv */
// Port checker for the mission setup block
`timescale 1ns/1ps
module mca_mission_chk (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic [15:0] i_addr,
  input wire logic        i_rd,
  input wire logic        i_start_mission,
  input wire logic        i_stop_mission,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_mission_active,
  input wire logic        o_waiting_alarm,
  input wire logic        o_start_refused,
  input wire logic        o_conv_8bit,
  input wire logic        o_mem_we,
  input wire logic [15:0] o_mem_addr,
  input wire logic [15:0] o_temp_base
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rd_setup;
    i_rd && i_addr == mca_pkg::ADDR_MISSION;
  endsequence
  sequence s_rd_alarm;
    i_rd && i_addr == mca_pkg::ADDR_ALARM;
  endsequence
  a_setup_top_ones: assert property (s_rd_setup |=> o_rdata[7:6] == 2'b11)
    else $error("setup top bits not one");
  a_alarm_fill_ones: assert property (s_rd_alarm |=> o_rdata[6:4] == 3'b111)
    else $error("alarm fill bits not one");
  a_power_flag_set: assert property (!$past(i_rst_n, 2) ##0 s_rd_alarm |=> o_rdata[7])
    else $error("power flag clear after reset");
  a_temp_base_fix: assert property (o_temp_base == mca_pkg::LOG_BASE)
    else $error("temperature base moved");
  a_stop_ends: assert property (o_mission_active && i_stop_mission |=> !o_mission_active)
    else $error("stop did not end mission");
  a_active_holds: assert property (o_mission_active && !i_stop_mission |=> o_mission_active)
    else $error("mission ended without stop");
  a_start_cause: assert property ($rose(o_mission_active) |-> $past(i_start_mission))
    else $error("mission began without start");
  a_refuse_idle: assert property ($rose(o_start_refused) |-> !o_mission_active)
    else $error("refused start went active");
  a_wait_8bit: assert property (o_waiting_alarm && o_mission_active |-> o_conv_8bit)
    else $error("alarm wait not 8-bit");
  a_log_in_range: assert property (o_mem_we |-> o_mem_addr inside {[mca_pkg::LOG_BASE:mca_pkg::LOG_END]})
    else $error("log write outside datalog");
endmodule : mca_mission_chk
bind mca_mission_config mca_mission_chk mca_mission_chk_inst (.i_sys_clk, .i_rst_n, .i_addr, .i_rd,
  .i_start_mission, .i_stop_mission, .o_rdata, .o_mission_active, .o_waiting_alarm, .o_start_refused,
  .o_conv_8bit, .o_mem_we, .o_mem_addr, .o_temp_base);

/* File: dv/mca_host_model.sv */
// Host model driving the register port
`timescale 1ns/1ps
module mca_host_model (
  input  wire logic        i_sys_clk,
  input  wire logic [7:0]  i_rdata,
  output logic      [15:0] o_addr,
  output logic      [7:0]  o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  initial
  begin
    o_addr = 16'h0000;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // Released lines show inverted values
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_sys_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : reg_wr
  task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask : reg_rd
endmodule : mca_host_model

/* File: dv/tb_top.sv */
// Self-checking bench for the mission setup block
`timescale 1ns/1ps
module tb_top;
  logic        i_sys_clk, i_rst_n, i_wr, i_rd, i_conv_forced;
  logic        i_start_mission, i_stop_mission, i_clear_memory, i_sample_tick, i_conv_done, i_ser_done;
  logic [15:0] i_addr, i_temp_value, i_ser_value;
  logic [7:0]  i_wdata, i_temp_low_thr, i_temp_high_thr, i_data_low_thr, i_data_high_thr, o_rdata, d;
  logic        o_mission_active, o_waiting_alarm, o_start_refused, o_conv_8bit, o_conv_enable, o_mem_we;
  logic [15:0] o_mem_addr, o_temp_base, o_ser_base;
  logic [7:0]  o_mem_wdata;
  logic [5:0]  cmd;
  int          err_total, n_compared, cyc;
  assign {i_ser_done, i_conv_done, i_sample_tick, i_clear_memory, i_stop_mission, i_start_mission} = cmd;
  mca_mission_config mca_mission_config_inst (.i_sys_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_start_mission, .i_stop_mission, .i_clear_memory, .i_sample_tick, .i_conv_done, .i_conv_forced,
    .i_temp_value, .i_temp_low_thr, .i_temp_high_thr, .i_ser_done, .i_ser_value, .i_data_low_thr,
    .i_data_high_thr, .o_mission_active, .o_waiting_alarm, .o_start_refused, .o_conv_8bit, .o_conv_enable,
    .o_mem_we, .o_mem_addr, .o_mem_wdata, .o_temp_base, .o_ser_base);
  mca_host_model mca_host_model_inst (.i_sys_clk, .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    mca_host_model_inst.reg_wr(a, v);
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    mca_host_model_inst.reg_rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask : rd
  task automatic pulse(input logic [5:0] c);
    @(posedge i_sys_clk);
    cmd <= c;
    @(posedge i_sys_clk);
    cmd <= 6'h00;
    #1;
  endtask : pulse
  task automatic exp_we(input logic [15:0] a, input logic [7:0] v);
    int k;
    k = 0;
    while (!o_mem_we && k < 8)
    begin
      @(posedge i_sys_clk);
      #1;
      k++;
    end
    chk({15'h0000, o_mem_we}, 16'h0001);
    chk(o_mem_addr, a);
    chk({8'h00, o_mem_wdata}, {8'h00, v});
    @(posedge i_sys_clk);
    #1;
  endtask : exp_we
  task automatic no_we();
    repeat (8)
    begin
      @(posedge i_sys_clk);
      #1;
      chk({15'h0000, o_mem_we}, 16'h0000);
    end
  endtask : no_we
  task automatic t_reset_regs();
    rd(mca_pkg::ADDR_ALARM, 8'hF0);
    rd(mca_pkg::ADDR_MISSION, 8'hC0);
    rd(16'h0300, 8'h00);
    wr(mca_pkg::ADDR_ALARM, 8'h00);
    rd(mca_pkg::ADDR_ALARM, 8'hF0);
    wr(mca_pkg::ADDR_MISSION, 8'h00);
    rd(mca_pkg::ADDR_MISSION, 8'hC0);
  endtask : t_reset_regs
  task automatic t_bases();
    logic [15:0] bt [4] = '{mca_pkg::SER_BASE_EQ, mca_pkg::SER_BASE_T16D8, mca_pkg::SER_BASE_T8D16,
                            mca_pkg::SER_BASE_EQ};
    for (int i = 0; i < 4; i++)
    begin
      wr(mca_pkg::ADDR_MISSION, {4'hC, i[1:0], 2'b11});
      chk(o_ser_base, bt[i]);
    end
    wr(mca_pkg::ADDR_MISSION, 8'hC2);
    chk(o_ser_base, 16'h1000);
    chk(o_temp_base, 16'h1000);
    wr(mca_pkg::ADDR_MISSION, 8'hC0);
    pulse(6'h01);
    chk({15'h0000, o_start_refused}, 16'h0001);
    chk({15'h0000, o_mission_active}, 16'h0000);
  endtask : t_bases
  task automatic t_log16();
    wr(mca_pkg::ADDR_SENS_CTRL, 8'h02);
    wr(mca_pkg::ADDR_MISSION, 8'hC5);
    pulse(6'h01);
    chk({15'h0000, o_mission_active}, 16'h0001);
    wr(mca_pkg::ADDR_MISSION, 8'h00);
    rd(mca_pkg::ADDR_MISSION, 8'hC5);
    i_temp_value <= 16'hA55A;
    pulse(6'h10);
    exp_we(16'h1000, 8'hA5);
    exp_we(16'h1001, 8'h5A);
    rd(mca_pkg::ADDR_ALARM, 8'hF2);
    pulse(6'h02);
    chk({15'h0000, o_mission_active}, 16'h0000);
    pulse(6'h04);
    rd(mca_pkg::ADDR_ALARM, 8'h70);
  endtask : t_log16
  task automatic t_log8();
    i_temp_low_thr <= 8'h40;
    wr(mca_pkg::ADDR_SENS_CTRL, 8'h03);
    wr(mca_pkg::ADDR_DATA_CTRL, 8'h01);
    wr(mca_pkg::ADDR_MISSION, 8'hC3);
    pulse(6'h01);
    i_temp_value <= 16'h3344;
    pulse(6'h10);
    exp_we(16'h1000, 8'h33);
    chk({15'h0000, o_mem_we}, 16'h0000);
    i_ser_value <= 16'h1020;
    pulse(6'h20);
    exp_we(mca_pkg::SER_BASE_EQ, 8'h10);
    chk({15'h0000, o_mem_we}, 16'h0000);
    rd(mca_pkg::ADDR_ALARM, 8'h75);
    pulse(6'h02);
    pulse(6'h04);
  endtask : t_log8
  task automatic t_start_on_temp_alarm();
    wr(mca_pkg::ADDR_MISSION, 8'hE1);
    pulse(6'h01);
    chk({15'h0000, o_waiting_alarm}, 16'h0001);
    chk({15'h0000, o_conv_8bit}, 16'h0001);
    i_temp_value <= 16'h5000;
    pulse(6'h10);
    no_we();
    i_temp_value <= 16'h9000;
    pulse(6'h10);
    no_we();
    chk({15'h0000, o_waiting_alarm}, 16'h0000);
    pulse(6'h08);
    pulse(6'h10);
    exp_we(16'h1000, 8'h90);
    rd(mca_pkg::ADDR_ALARM, 8'h72);
    pulse(6'h02);
  endtask : t_start_on_temp_alarm
  task automatic t_forced();
    pulse(6'h04);
    rd(mca_pkg::ADDR_ALARM, 8'h70);
    i_conv_forced <= 1'b1;
    pulse(6'h14);
    rd(mca_pkg::ADDR_ALARM, 8'h72);
    i_conv_forced <= 1'b0;
    pulse(6'h04);
    pulse(6'h10);
    rd(mca_pkg::ADDR_ALARM, 8'h70);
    wr(mca_pkg::ADDR_MISSION, 8'hE2);
    pulse(6'h01);
    chk({15'h0000, o_waiting_alarm}, 16'h0000);
    chk({15'h0000, o_mission_active}, 16'h0001);
    pulse(6'h02);
  endtask : t_forced
  task automatic t_fill();
    for (int w = 0; w < 2; w++)
    begin
      wr(mca_pkg::ADDR_MISSION, w ? 8'hD5 : 8'hC5);
      pulse(6'h01);
      repeat (4096)
      begin
        pulse(6'h10);
        repeat (2) @(posedge i_sys_clk);
      end
      #1;
      chk({15'h0000, o_mission_active}, 16'h0001);
      chk({15'h0000, o_conv_enable}, {15'h0000, w[0]});
      pulse(6'h10);
      if (w)
      begin
        exp_we(16'h1000, 8'h90);
        exp_we(16'h1001, 8'h00);
      end
      else
      begin
        no_we();
      end
      pulse(6'h02);
    end
  endtask : t_fill
  task automatic close_out();
    $display("Mismatches %0d of %0d comparisons", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  initial
  begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      close_out();
    end
  end
  initial
  begin
    {i_rst_n, i_conv_forced, cmd, cyc, err_total, n_compared} = '0;
    {i_temp_value, i_ser_value, i_temp_high_thr, i_data_low_thr} = {32'h0000_0000, 16'h8020};
    {i_temp_low_thr, i_data_high_thr} = 16'hFFFF;
    repeat (16) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    t_reset_regs();
    t_bases();
    t_log16();
    t_log8();
    t_start_on_temp_alarm();
    t_forced();
    t_fill();
    close_out();
  end
endmodule : tb_top
